// file: src/swrl_pkg.sv
// Shared constants, types and the identity check function of the single-wire ROM layer
package swrl_pkg;
	// ==========================================================
	// Clock and timing
	localparam int CLK_NS = 10; // ref_clk period
	localparam int CNT_W = 17;
	typedef logic [CNT_W-1:0] swrl_cnt_t;
	localparam swrl_cnt_t CNT_MAX = {CNT_W{1'b1}};

	// Least time in whole cycles, never below one
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_up

	localparam int T_RST_DET_NS = 480000;
	localparam int T_PRS_WAIT_NS = 30000;
	localparam int T_PRS_LOW_NS = 120000;
	localparam int T_DEV_SAMP_NS = 30000;
	localparam int T_RST_LOW_NS = 500000;
	localparam int T_PRS_SAMP_NS = 70000;
	localparam int T_RST_REC_NS = 480000;
	localparam int T_W1_LOW_NS = 6000;
	localparam int T_W0_LOW_NS = 60000;
	localparam int T_RD_SAMP_NS = 12000;
	localparam int T_SLOT_NS = 70000;

	localparam int RST_DET_CYC = cyc_up(T_RST_DET_NS);
	localparam int PRS_WAIT_CYC = cyc_up(T_PRS_WAIT_NS);
	localparam int PRS_LOW_CYC = cyc_up(T_PRS_LOW_NS);
	localparam int DEV_SAMP_CYC = cyc_up(T_DEV_SAMP_NS);
	localparam int RST_LOW_CYC = cyc_up(T_RST_LOW_NS);
	localparam int PRS_SAMP_CYC = cyc_up(T_PRS_SAMP_NS);
	localparam int PRS_END_CYC = cyc_up(T_RST_REC_NS);
	localparam int W1_LOW_CYC = cyc_up(T_W1_LOW_NS);
	localparam int W0_LOW_CYC = cyc_up(T_W0_LOW_NS);
	localparam int RD_SAMP_CYC = cyc_up(T_RD_SAMP_NS);
	localparam int SLOT_CYC = cyc_up(T_SLOT_NS);

	// ==========================================================
	// ROM function codes and check polynomial (reflected form)
	localparam logic [7:0] CMD_READ_ID = 8'h33;
	localparam logic [7:0] CMD_MATCH = 8'h55;
	localparam logic [7:0] CMD_SKIP = 8'hCC;
	localparam logic [7:0] CMD_SEARCH = 8'hF0;
	localparam logic [7:0] CRC_POLY_R = 8'h8C;
	localparam logic [5:0] LAST_ID_BIT = 6'h3F;
	localparam logic [5:0] LAST_BYTE_BIT = 6'h07;

	// Check byte over family code and serial, first bit first
	function automatic logic [7:0] crc8_id(input logic [55:0] dat);
		logic [7:0] c;
		logic fb;
		c = 8'h00;
		for (int i = 0; i < 56; i++)
		begin
			fb = c[0] ^ dat[i];
			c = {1'b0, c[7:1]};
			if (fb)
				c = c ^ CRC_POLY_R;
		end
		return c;
	endfunction : crc8_id

	// ==========================================================
	// State types
	typedef enum logic [3:0] {D_IDLE, D_RST, D_PRS_WAIT, D_PRS_LOW, D_PRS_END,
		D_CMD, D_READ, D_MATCH, D_SEARCH, D_FUNC, D_DONE} swrl_dst_t;
	typedef enum logic [1:0] {M_IDLE, M_RST_LOW, M_RST_WAIT, M_SLOT} swrl_mst_t;
	typedef enum logic [2:0] {REQ_RESET, REQ_WBIT, REQ_RBIT, REQ_WBYTE, REQ_RBYTE,
		REQ_TRIP} swrl_req_t;
endpackage : swrl_pkg

// file: src/swrl_if.sv
// Shared open-drain data line joining the device end and the master end
`timescale 1ns/1ps
interface swrl_if;
	logic dev_oe;
	logic dev_o;
	logic mst_oe;
	logic mst_o;
	logic line;

	// Pull-up idles the line high; any enabled low driver wins
	assign line = !((dev_oe && !dev_o) || (mst_oe && !mst_o));

	modport dev (input line, output dev_oe, output dev_o);
	modport mst (input line, output mst_oe, output mst_o);
endinterface : swrl_if

// file: src/swrl_dev.sv
// Device end: reset and presence, ROM commands, selection and hand-over
//
// Notes on behaviour
// - Identity: family low, serial, check byte high
// - All fields travel least significant bit first
// - Device only pulls low or releases line
// - High line between bits keeps transaction state
// - Low beyond 480 us is bus reset
// - Reset, ROM command, memory command, then data; the device stops in D_DONE after the memory command and takes no data
// - Master reset pulse answered by presence pulse
// - Whole 8-bit ROM command received before acting
// - Code 33h sends whole identity word
// - Read identity only with one slave attached
// - Code 55h compares 64 bits, all must match
// - Mismatched device ignores traffic until reset
// - Code CCh goes straight to memory command
// - No memory read after skip with many slaves
// - Search: send bit, complement, read master bit
// - Search mismatch drops device for that pass
// - Master repeats search step, new reset each pass
// - Master decodes two search reads as given
// - Memory commands refused before ROM phase completes
// - Check byte polynomial x8+x5+x4+1, start zero
`timescale 1ns/1ps
module swrl_dev #(
	parameter logic [7:0] FAMILY = 8'hA5, // Arbitrary value
	parameter logic [47:0] SERIAL = 48'h0000_0012_3456, // Arbitrary value
	parameter int RST_DET_CYC = swrl_pkg::RST_DET_CYC,
	parameter int PRS_LOW_CYC = swrl_pkg::PRS_LOW_CYC,
	parameter int PRS_WAIT_CYC = swrl_pkg::PRS_WAIT_CYC,
	parameter int DEV_SAMP_CYC = swrl_pkg::DEV_SAMP_CYC
)(
	input wire logic ref_clk,
	input wire logic sys_rst,
	swrl_if.dev bus,
	output logic sel_q,
	output logic fn_valid_q,
	output logic [7:0] fn_cmd_q,
	output logic bus_rst_q,
	output logic [7:0] rom_cmd_q
);
	// ==========================================================
	// Identity word and timing
	localparam logic [7:0] CHECK = swrl_pkg::crc8_id({SERIAL, FAMILY});
	localparam logic [63:0] ID = {CHECK, SERIAL, FAMILY};
	localparam swrl_pkg::swrl_cnt_t C_RST = swrl_pkg::swrl_cnt_t'(RST_DET_CYC);
	localparam swrl_pkg::swrl_cnt_t C_PLOW = swrl_pkg::swrl_cnt_t'(PRS_LOW_CYC);
	localparam swrl_pkg::swrl_cnt_t C_PWAIT = swrl_pkg::swrl_cnt_t'(PRS_WAIT_CYC);
	localparam swrl_pkg::swrl_cnt_t C_SAMP = swrl_pkg::swrl_cnt_t'(DEV_SAMP_CYC);

	typedef struct packed {
		logic [2:0] s;
		logic lvl;
		swrl_pkg::swrl_dst_t st;
		swrl_pkg::swrl_cnt_t cnt;
		logic [5:0] idx;
		logic [1:0] ph;
		logic [7:0] sh;
		logic hit;
		logic oe;
		logic o;
		logic sel;
		logic fn_valid;
		logic [7:0] fn_cmd;
		logic bus_rst;
		logic [7:0] rom_cmd;
	} swrl_dev_s_t;

	localparam swrl_dev_s_t RST_VAL = '{s: 3'h7, lvl: 1'b1, st: swrl_pkg::D_IDLE,
		cnt: swrl_pkg::CNT_MAX, default: '0};

	swrl_dev_s_t q;
	swrl_dev_s_t d;
	logic fall;
	logic tx;
	logic txb;
	logic low_long;
	logic [7:0] nb;

	// ==========================================================
	// Line events
	// Filtered level only moves when the last two stages agree
	assign fall = q.lvl && (q.s[1] == q.s[2]) && !q.s[2];
	assign low_long = !q.lvl && (q.cnt >= C_RST);
	// Slots in which this device answers, and the bit it answers
	assign tx = (q.st == swrl_pkg::D_READ) || ((q.st == swrl_pkg::D_SEARCH) && (q.ph != 2'h2));
	assign txb = ID[q.idx] ^ ((q.st == swrl_pkg::D_SEARCH) && (q.ph == 2'h1));
	assign nb = {q.lvl, q.sh[7:1]};

	// ==========================================================
	// Next state
	always_comb
	begin
		d = q;
		d.s = {q.s[1:0], bus.line};
		d.fn_valid = 1'b0;
		d.bus_rst = 1'b0;
		if (q.s[1] == q.s[2])
			d.lvl = q.s[2];
		// Time since the last falling edge, held at the top
		if (fall)
			d.cnt = '0;
		else if (q.cnt != swrl_pkg::CNT_MAX)
			d.cnt = q.cnt + 1'b1;
		case (q.st)
			swrl_pkg::D_RST:
			begin
				if (q.lvl)
				begin
					d.st = swrl_pkg::D_PRS_WAIT;
					d.cnt = '0;
				end
			end
			swrl_pkg::D_PRS_WAIT:
			begin
				if (q.cnt == C_PWAIT)
				begin
					d.oe = 1'b1;
					d.cnt = '0;
					d.st = swrl_pkg::D_PRS_LOW;
				end
			end
			swrl_pkg::D_PRS_LOW:
			begin
				if (q.cnt == C_PLOW)
				begin
					d.oe = 1'b0;
					d.st = swrl_pkg::D_PRS_END;
				end
			end
			swrl_pkg::D_PRS_END:
			begin
				// Other slaves may hold presence longer; wait for release
				if (q.lvl)
				begin
					d.st = swrl_pkg::D_CMD;
					d.idx = '0;
					d.cnt = swrl_pkg::CNT_MAX;
				end
			end
			swrl_pkg::D_CMD, swrl_pkg::D_READ, swrl_pkg::D_MATCH,
			swrl_pkg::D_SEARCH, swrl_pkg::D_FUNC:
			begin
				// A zero is sent by pulling low; a one by leaving the line
				if (fall && tx && !txb)
					d.oe = 1'b1;
				// Slots wait on the master's edges only, so any pause is fine
				if (q.cnt == C_SAMP)
				begin
					d.oe = 1'b0;
					case (q.st)
						swrl_pkg::D_CMD, swrl_pkg::D_FUNC:
						begin
							d.sh = nb;
							d.idx = q.idx + 6'h01;
							if (q.idx == swrl_pkg::LAST_BYTE_BIT)
							begin
								d.idx = '0;
								if (q.st == swrl_pkg::D_FUNC)
								begin
									d.fn_cmd = nb;
									d.fn_valid = 1'b1;
									d.st = swrl_pkg::D_DONE;
								end
								else
								begin
									d.rom_cmd = nb;
									d.hit = 1'b1;
									case (nb)
										swrl_pkg::CMD_READ_ID: d.st = swrl_pkg::D_READ;
										swrl_pkg::CMD_MATCH: d.st = swrl_pkg::D_MATCH;
										swrl_pkg::CMD_SEARCH: d.st = swrl_pkg::D_SEARCH;
										swrl_pkg::CMD_SKIP:
										begin
											d.sel = 1'b1;
											d.st = swrl_pkg::D_FUNC;
										end
										default: d.st = swrl_pkg::D_IDLE;
									endcase
								end
							end
						end
						swrl_pkg::D_READ:
						begin
							d.idx = q.idx + 6'h01;
							if (q.idx == swrl_pkg::LAST_ID_BIT)
							begin
								d.sel = 1'b1;
								d.st = swrl_pkg::D_FUNC;
							end
						end
						swrl_pkg::D_MATCH:
						begin
							d.idx = q.idx + 6'h01;
							if (q.lvl != ID[q.idx])
								d.hit = 1'b0;
							if (q.idx == swrl_pkg::LAST_ID_BIT)
							begin
								// Any miss parks the device until the next reset
								if (q.hit && (q.lvl == ID[q.idx]))
								begin
									d.sel = 1'b1;
									d.st = swrl_pkg::D_FUNC;
								end
								else
									d.st = swrl_pkg::D_IDLE;
							end
						end
						swrl_pkg::D_SEARCH:
						begin
							if (q.ph != 2'h2)
								d.ph = q.ph + 2'h1;
							else if (q.lvl != ID[q.idx])
								d.st = swrl_pkg::D_IDLE;
							else if (q.idx == swrl_pkg::LAST_ID_BIT)
							begin
								d.sel = 1'b1;
								d.idx = '0;
								d.st = swrl_pkg::D_FUNC;
							end
							else
							begin
								d.ph = 2'h0;
								d.idx = q.idx + 6'h01;
							end
						end
						default: d.st = q.st;
					endcase
				end
			end
			// Idle and done ignore slots; only a bus reset leaves them
			default: d.st = q.st;
		endcase
		// A long low abandons everything, whatever the state
		if (low_long)
		begin
			d.st = swrl_pkg::D_RST;
			d.oe = 1'b0;
			d.sel = 1'b0;
			d.idx = '0;
			d.ph = 2'h0;
			d.bus_rst = (q.st != swrl_pkg::D_RST);
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			q <= RST_VAL;
		else
			q <= d;
	end

	// ==========================================================
	// Outputs, all from the state register
	assign bus.dev_oe = q.oe;
	assign bus.dev_o = q.o;
	assign sel_q = q.sel;
	assign fn_valid_q = q.fn_valid;
	assign fn_cmd_q = q.fn_cmd;
	assign bus_rst_q = q.bus_rst;
	assign rom_cmd_q = q.rom_cmd;
endmodule : swrl_dev

// file: src/swrl_mst.sv
// Master end: reset pulse, write and read slots, bytes and search steps
`timescale 1ns/1ps
module swrl_mst #(
	parameter int RST_LOW_CYC = swrl_pkg::RST_LOW_CYC,
	parameter int PRS_SAMP_CYC = swrl_pkg::PRS_SAMP_CYC,
	parameter int PRS_END_CYC = swrl_pkg::PRS_END_CYC,
	parameter int W0_LOW_CYC = swrl_pkg::W0_LOW_CYC,
	parameter int SLOT_CYC = swrl_pkg::SLOT_CYC,
	parameter int W1_LOW_CYC = swrl_pkg::W1_LOW_CYC,
	parameter int RD_SAMP_CYC = swrl_pkg::RD_SAMP_CYC
)(
	input wire logic ref_clk,
	input wire logic sys_rst,
	swrl_if.mst bus,
	input wire logic req_valid,
	input wire swrl_pkg::swrl_req_t req_kind,
	input wire logic [7:0] req_data,
	output logic ready_q,
	output logic done_q,
	output logic [7:0] rsp_q,
	output logic presence_q,
	output logic [1:0] trip_q
);
	// ==========================================================
	// Timing in cycles
	localparam swrl_pkg::swrl_cnt_t C_RLOW = swrl_pkg::swrl_cnt_t'(RST_LOW_CYC);
	localparam swrl_pkg::swrl_cnt_t C_PSAMP = swrl_pkg::swrl_cnt_t'(PRS_SAMP_CYC);
	localparam swrl_pkg::swrl_cnt_t C_PEND = swrl_pkg::swrl_cnt_t'(PRS_END_CYC);
	localparam swrl_pkg::swrl_cnt_t C_W0 = swrl_pkg::swrl_cnt_t'(W0_LOW_CYC);
	localparam swrl_pkg::swrl_cnt_t C_SLOT = swrl_pkg::swrl_cnt_t'(SLOT_CYC);
	localparam swrl_pkg::swrl_cnt_t C_W1 = swrl_pkg::swrl_cnt_t'(W1_LOW_CYC);
	localparam swrl_pkg::swrl_cnt_t C_RS = swrl_pkg::swrl_cnt_t'(RD_SAMP_CYC);

	typedef struct packed {
		logic [2:0] s;
		logic lvl;
		swrl_pkg::swrl_mst_t st;
		swrl_pkg::swrl_req_t kind;
		swrl_pkg::swrl_cnt_t cnt;
		logic [3:0] left;
		logic [1:0] ph;
		logic [7:0] sh;
		logic wb;
		logic dir;
		logic r0;
		logic rb;
		logic oe;
		logic o;
		logic ready;
		logic done;
		logic [7:0] rsp;
		logic pres;
		logic [1:0] trip;
	} swrl_mst_s_t;

	localparam swrl_mst_s_t RST_VAL = '{s: 3'h7, lvl: 1'b1, st: swrl_pkg::M_IDLE,
		kind: swrl_pkg::REQ_RESET, ready: 1'b1, default: '0};

	swrl_mst_s_t q;
	swrl_mst_s_t d;
	logic wr;
	logic bitv;
	logic [7:0] nsh;

	// Slot direction and the bit a write slot carries
	assign wr = (q.kind == swrl_pkg::REQ_WBIT) || (q.kind == swrl_pkg::REQ_WBYTE)
		|| ((q.kind == swrl_pkg::REQ_TRIP) && (q.ph == 2'h2));
	assign bitv = (q.kind == swrl_pkg::REQ_TRIP) ? q.wb : q.sh[0];
	assign nsh = wr ? {1'b0, q.sh[7:1]} : {q.rb, q.sh[7:1]};

	// ==========================================================
	// Next state
	always_comb
	begin
		logic fin;
		logic go;
		fin = 1'b0;
		go = 1'b0;
		d = q;
		d.s = {q.s[1:0], bus.line};
		d.done = 1'b0;
		if (q.s[1] == q.s[2])
			d.lvl = q.s[2];
		if (q.st != swrl_pkg::M_IDLE)
			d.cnt = q.cnt + 1'b1;
		case (q.st)
			swrl_pkg::M_IDLE:
			begin
				// Any pause here leaves the line high, which keeps slaves waiting
				if (req_valid && q.ready)
				begin
					d.ready = 1'b0;
					d.kind = req_kind;
					d.sh = req_data;
					d.dir = req_data[0];
					d.ph = 2'h0;
					d.cnt = '0;
					d.oe = 1'b1;
					d.left = ((req_kind == swrl_pkg::REQ_WBYTE) || (req_kind == swrl_pkg::REQ_RBYTE))
						? 4'h8 : 4'h1;
					d.st = (req_kind == swrl_pkg::REQ_RESET) ? swrl_pkg::M_RST_LOW : swrl_pkg::M_SLOT;
				end
			end
			swrl_pkg::M_RST_LOW:
			begin
				if (q.cnt == C_RLOW)
				begin
					d.oe = 1'b0;
					d.cnt = '0;
					d.st = swrl_pkg::M_RST_WAIT;
				end
			end
			swrl_pkg::M_RST_WAIT:
			begin
				if (q.cnt == C_PSAMP)
					d.pres = !q.lvl;
				if (q.cnt == C_PEND)
					fin = 1'b1;
			end
			swrl_pkg::M_SLOT:
			begin
				if (q.cnt == ((wr && !bitv) ? C_W0 : C_W1))
					d.oe = 1'b0;
				if (!wr && (q.cnt == C_RS))
					d.rb = q.lvl;
				if (q.cnt == C_SLOT)
				begin
					if (q.kind == swrl_pkg::REQ_TRIP)
					begin
						case (q.ph)
							2'h0:
							begin
								d.r0 = q.rb;
								d.ph = 2'h1;
								go = 1'b1;
							end
							2'h1:
							begin
								d.trip = {q.r0, q.rb};
								d.wb = (q.r0 != q.rb) ? q.r0 : q.dir;
								d.ph = 2'h2;
								if (q.r0 && q.rb)
									fin = 1'b1;
								else
									go = 1'b1;
							end
							default: fin = 1'b1;
						endcase
					end
					else
					begin
						d.sh = nsh;
						d.left = q.left - 4'h1;
						if (q.left == 4'h1)
							fin = 1'b1;
						else
							go = 1'b1;
					end
				end
			end
			default: d.st = swrl_pkg::M_IDLE;
		endcase
		// Next slot restarts the counter with the line pulled low
		if (go)
		begin
			d.cnt = '0;
			d.oe = 1'b1;
		end
		if (fin)
		begin
			d.st = swrl_pkg::M_IDLE;
			d.ready = 1'b1;
			d.done = 1'b1;
			d.oe = 1'b0;
			if (q.kind == swrl_pkg::REQ_RBIT)
				d.rsp = {7'h00, q.rb};
			else if (q.kind == swrl_pkg::REQ_TRIP)
				d.rsp = {7'h00, d.wb};
			else
				d.rsp = nsh;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			q <= RST_VAL;
		else
			q <= d;
	end

	assign bus.mst_oe = q.oe;
	assign bus.mst_o = q.o;
	assign ready_q = q.ready;
	assign done_q = q.done;
	assign rsp_q = q.rsp;
	assign presence_q = q.pres;
	assign trip_q = q.trip;
endmodule : swrl_mst

// file: verif/swrl_assertions.sv
// Checker of the shared single-wire line between the device and master ends
`timescale 1ns/1ps
module swrl_assertions #(
	parameter int RST_DET_CYC = 4000,
	parameter int PRS_LOW_CYC = 2000,
	parameter int W0_LOW_CYC = 3200,
	parameter int PRS_WAIT_CYC = swrl_pkg::PRS_WAIT_CYC,
	parameter int DEV_SAMP_CYC = swrl_pkg::DEV_SAMP_CYC
)(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic dev_oe,
	input wire logic dev_o,
	input wire logic mst_oe,
	input wire logic mst_o,
	input wire logic line
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// Helper counters
	localparam int PRS_MIN = PRS_WAIT_CYC - 5; // Presence wait less a five-cycle margin
	localparam int PRS_MAX = PRS_WAIT_CYC + 12;
	localparam int RPL_MIN = DEV_SAMP_CYC - 10; // Read reply lasts about the device sample time
	localparam int RPL_MAX = DEV_SAMP_CYC + 12;
	logic [16:0] low_q;
	logic [16:0] age_q;
	logic seen_q;
	logic [16:0] dhi_q;
	logic [16:0] mhi_q;
	logic prs_q;
	logic armed_q;

	// Run lengths; prs_q marks a pulse begun on a released line, armed_q a seen bus reset
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			low_q <= 17'h00000;
			dhi_q <= 17'h00000;
			mhi_q <= 17'h00000;
			prs_q <= 1'b0;
			armed_q <= 1'b0;
			age_q <= 17'h00000;
			seen_q <= 1'b0;
		end
		else
		begin
			low_q <= line ? 17'h00000 : low_q + 17'h00001;
			dhi_q <= dev_oe ? dhi_q + 17'h00001 : 17'h00000;
			mhi_q <= mst_oe ? mhi_q + 17'h00001 : 17'h00000;
			if (dev_oe && dhi_q == 17'h00000)
				prs_q <= !mst_oe;
			if (low_q >= 17'(RST_DET_CYC))
				armed_q <= 1'b1;
			else if (dev_oe)
				armed_q <= 1'b0;
			// Age since a bus reset ended; a counter, as the wait is too long for a delay range
			if (line && low_q >= 17'(RST_DET_CYC))
			begin
				age_q <= 17'h00001;
				seen_q <= 1'b0;
			end
			else
			begin
				if (age_q != 17'h00000 && age_q != 17'h1FFFF)
					age_q <= age_q + 17'h00001;
				if (dev_oe && age_q != 17'h00000)
					seen_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Sequences and properties
	sequence s_presence_due;
		age_q == 17'(PRS_MAX);
	endsequence
	sequence s_presence_rise;
		$rose(dev_oe) && armed_q;
	endsequence

	property p_dev_open_drain;
		!dev_o;
	endproperty
	a_dev_open_drain: assert property (p_dev_open_drain) else $error("device drives line high");
	property p_mst_open_drain;
		!mst_o;
	endproperty
	a_mst_open_drain: assert property (p_mst_open_drain) else $error("master drives line high");
	property p_presence_start;
		s_presence_due |-> seen_q;
	endproperty
	a_presence_start: assert property (p_presence_start) else $error("no presence after bus reset");
	property p_presence_early;
		s_presence_rise |-> age_q >= 17'(PRS_MIN);
	endproperty
	a_presence_early: assert property (p_presence_early) else $error("presence before its wait");
	// The device sees its own pulse as a fall, which restarts its count
	property p_presence_width;
		$fell(dev_oe) && prs_q |-> dhi_q >= 17'(PRS_LOW_CYC + 4) && dhi_q <= 17'(PRS_LOW_CYC + 7);
	endproperty
	a_presence_width: assert property (p_presence_width) else $error("presence pulse width wrong");
	property p_presence_cause;
		$rose(dev_oe) && !mst_oe |-> armed_q;
	endproperty
	a_presence_cause: assert property (p_presence_cause) else $error("device pulled idle line");
	property p_reset_abort;
		low_q == 17'(RST_DET_CYC + 8) |-> !dev_oe;
	endproperty
	a_reset_abort: assert property (p_reset_abort) else $error("device still drives after bus reset");
	property p_reply_cause;
		$rose(dev_oe) && mst_oe |-> !$past(mst_oe, 8);
	endproperty
	a_reply_cause: assert property (p_reply_cause) else $error("reply not tied to a slot start");
	property p_reply_width;
		$fell(dev_oe) && !prs_q |-> dhi_q >= 17'(RPL_MIN) && dhi_q <= 17'(RPL_MAX);
	endproperty
	a_reply_width: assert property (p_reply_width) else $error("read reply width wrong");
	property p_master_pulse;
		$fell(mst_oe) |-> mhi_q <= 17'(W0_LOW_CYC + 2) || mhi_q >= 17'(RST_DET_CYC);
	endproperty
	a_master_pulse: assert property (p_master_pulse) else $error("master low pulse of no known kind");
endmodule : swrl_assertions

// file: verif/tb_top.sv
// Testbench joining the device and master ends over the shared line
`timescale 1ns/1ps
module tb_top;
	// ==========================================================
	// Parameters and signals
	localparam logic [7:0] FAM = 8'h3C; // Arbitrary value
	localparam logic [47:0] SER = 48'h00A1_B2C3_D4E5; // Arbitrary value
	// Timing shrunk to keep the run short; sample points keep their order
	localparam int RST_DET = 100;
	localparam int PRS_WAIT = 30;
	localparam int PRS_LOW = 60;
	localparam int DEV_SAMP = 30;
	localparam int W1_LOW = 6;
	localparam int RD_SAMP = 15;
	localparam int W0_LOW = 40;
	localparam int SLOT = 55;
	localparam int LIMIT = 40000; // About 15000 cycles expected
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic req_valid = 1'b0;
	swrl_pkg::swrl_req_t req_kind = swrl_pkg::REQ_RESET;
	logic [7:0] req_data = 8'h00;
	logic ready_q, done_q, presence_q, sel_q, fn_valid_q, bus_rst_q;
	logic [7:0] rsp_q, fn_cmd_q, rom_cmd_q;
	logic [1:0] trip_q;
	logic [63:0] id;
	int fail_count = 0;
	int comparisons = 0;
	int fn_cnt = 0;
	int rst_cnt = 0;
	int cyc = 0;

	swrl_if bus_if();
	swrl_dev #(.FAMILY(FAM), .SERIAL(SER), .RST_DET_CYC(RST_DET), .PRS_LOW_CYC(PRS_LOW),
		.PRS_WAIT_CYC(PRS_WAIT), .DEV_SAMP_CYC(DEV_SAMP)) u_swrl_dev (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus_if.dev), .sel_q(sel_q), .fn_valid_q(fn_valid_q),
		.fn_cmd_q(fn_cmd_q), .bus_rst_q(bus_rst_q), .rom_cmd_q(rom_cmd_q));
	swrl_mst #(.RST_LOW_CYC(120), .PRS_SAMP_CYC(60), .PRS_END_CYC(150), .W0_LOW_CYC(W0_LOW),
		.SLOT_CYC(SLOT), .W1_LOW_CYC(W1_LOW), .RD_SAMP_CYC(RD_SAMP)) u_swrl_mst (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus_if.mst), .req_valid(req_valid), .req_kind(req_kind),
		.req_data(req_data), .ready_q(ready_q), .done_q(done_q), .rsp_q(rsp_q), .presence_q(presence_q),
		.trip_q(trip_q));
	swrl_assertions #(.RST_DET_CYC(RST_DET), .PRS_LOW_CYC(PRS_LOW), .W0_LOW_CYC(W0_LOW),
		.PRS_WAIT_CYC(PRS_WAIT), .DEV_SAMP_CYC(DEV_SAMP)) u_swrl_assertions (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .dev_oe(bus_if.dev_oe), .dev_o(bus_if.dev_o),
		.mst_oe(bus_if.mst_oe), .mst_o(bus_if.mst_o), .line(bus_if.line));

	// ==========================================================
	// Clock, pulse counters and hang guard
	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cyc++;
		if (fn_valid_q === 1'b1)
			fn_cnt++;
		if (bus_rst_q === 1'b1)
			rst_cnt++;
		if (cyc == LIMIT)
		begin
			fail_count++;
			finish_test();
		end
	end

	// ==========================================================
	// Tasks
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// Ready stands until taken, so raising valid after seeing it avoids an edge race
	task automatic run(input swrl_pkg::swrl_req_t k, input logic [7:0] d);
		@(negedge ref_clk);
		while (ready_q !== 1'b1)
			@(negedge ref_clk);
		req_valid = 1'b1;
		req_kind = k;
		req_data = d;
		@(negedge ref_clk);
		req_valid = 1'b0;
		while (done_q !== 1'b1)
			@(negedge ref_clk);
	endtask : run

	task automatic bus_reset(input int n);
		run(swrl_pkg::REQ_RESET, 8'h00);
		check(presence_q, 1'b1);
		check(rst_cnt, n);
		check(sel_q, 1'b0);
	endtask : bus_reset

	// Independent model of the identity check byte
	function automatic logic [7:0] crc_ref(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++)
			c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
		return c;
	endfunction : crc_ref

	// ==========================================================
	// Main sequence
	initial
	begin
		id = {crc_ref({SER, FAM}), SER, FAM};
		repeat (4) @(negedge ref_clk);
		sys_rst = 1'b0;
		check(bus_if.line, 1'b1);
		// Skip addressing hands the next byte on
		bus_reset(1);
		run(swrl_pkg::REQ_WBYTE, swrl_pkg::CMD_SKIP);
		check(rom_cmd_q, swrl_pkg::CMD_SKIP);
		check(sel_q, 1'b1);
		run(swrl_pkg::REQ_WBYTE, 8'hB2);
		check(fn_cnt, 1);
		check(fn_cmd_q, 8'hB2);
		// Unknown ROM code leaves memory commands refused
		bus_reset(2);
		run(swrl_pkg::REQ_WBYTE, 8'hB2);
		run(swrl_pkg::REQ_WBYTE, 8'h11);
		check(rom_cmd_q, 8'hB2);
		check(fn_cnt, 1);
		// Identity read, bytes in order, check byte last
		bus_reset(3);
		run(swrl_pkg::REQ_WBYTE, swrl_pkg::CMD_READ_ID);
		for (int i = 0; i < 8; i++)
		begin
			run(swrl_pkg::REQ_RBYTE, 8'hFF);
			check(rsp_q, id[8*i +: 8]);
		end
		check(sel_q, 1'b1);
		// Addressed match with a long high pause in the middle
		bus_reset(4);
		run(swrl_pkg::REQ_WBYTE, swrl_pkg::CMD_MATCH);
		for (int i = 0; i < 8; i++)
		begin
			run(swrl_pkg::REQ_WBYTE, id[8*i +: 8]);
			if (i == 3)
				repeat (RST_DET + 1000) @(negedge ref_clk);
		end
		check(sel_q, 1'b1);
		run(swrl_pkg::REQ_WBYTE, 8'hB4);
		check(fn_cnt, 2);
		check(fn_cmd_q, 8'hB4);
		// Search steps, a wrong direction drops the device out
		bus_reset(5);
		run(swrl_pkg::REQ_WBYTE, swrl_pkg::CMD_SEARCH);
		for (int i = 0; i < 6; i++)
		begin
			if (i == 4)
			begin
				// A master step follows a unanimous bit, so oppose the device by hand
				run(swrl_pkg::REQ_RBIT, 8'hFF);
				check(rsp_q, {7'h00, id[i]});
				run(swrl_pkg::REQ_RBIT, 8'hFF);
				check(rsp_q, {7'h00, ~id[i]});
				run(swrl_pkg::REQ_WBIT, {7'h00, ~id[i]});
			end
			else
			begin
				run(swrl_pkg::REQ_TRIP, {7'h00, id[i]});
				check(trip_q, (i == 5) ? 2'b11 : {id[i], ~id[i]});
				check(rsp_q, {7'h00, id[i]});
			end
		end
		check(sel_q, 1'b0);
		run(swrl_pkg::REQ_WBYTE, 8'h11);
		check(fn_cnt, 2);
		// Reset in mid-search restores presence
		bus_reset(6);
		finish_test();
	end
endmodule : tb_top
